// >>> hdl/acotb_bank.sv
// offset trim register bank with wishbone slave and per-core offset selection
// Operation
// - core a, input 1, phase 0 uses 0x344
// - core a, input 2, phase 0 uses 0x346
// - core a, input 1, phase 90 uses 0x348
// - core a, input 2, phase 90 uses 0x34a
// - core b, input 1, phase 0 uses 0x34c
// - 16-bit registers, offset in 11:0
// - fuse defaults loaded, software reads and overwrites
// - core b, input 2, phase 0 uses 0x34e
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acotb_bank (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone classic slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [11:0]             adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // factory fuse defaults, one 16-bit word per register, same clock domain
  input  wire logic [6*16-1:0]         fuse_data_i,
  input  wire logic                    fuse_load_i,
  // offsets applied to the two cores
  output acotb_pkg::acotb_trim_type    core_a_trim_o,
  output acotb_pkg::acotb_trim_type    core_b_trim_o
);
  import acotb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [ACOTB_TRIM_W-1:0] trim [ACOTB_NREG];       // trim registers
  logic [ACOTB_TRIM_W-1:0] next_trim [ACOTB_NREG];
  logic [3:0]              ctrl;                    // calibration control
  logic [3:0]              next_ctrl;
  logic                    fuse_pend;               // fuse copy owed after reset
  logic                    next_fuse_pend;
  logic                    ack;                     // bus answer
  logic                    next_ack;
  logic [31:0]             rdata;                   // registered read data
  logic [31:0]             next_rdata;
  acotb_trim_type          trim_a;                  // applied core a offset
  acotb_trim_type          next_trim_a;
  acotb_trim_type          trim_b;                  // applied core b offset
  acotb_trim_type          next_trim_b;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic       req;          // new access, answered one cycle later
  logic [2:0] hit_idx;      // trim register index
  logic       hit_trim;     // access lands on a trim register
  logic       wr_lo;        // low byte lane enabled
  logic       wr_hi;        // high byte lane enabled

  // ack drops after one cycle, so a held request is not taken twice
  assign req   = cyc_i && stb_i && !ack;
  // byte lanes 3:2 carry nothing, the words are only 16 bits wide
  assign wr_lo = sel_i[0];
  assign wr_hi = sel_i[1];

  // trim registers sit at half-word steps from the first offset
  // anything else falls to the default; apart from control and status it reads as zero
  always_comb begin
    hit_trim = 1'b0;
    hit_idx  = 3'h0;
    unique case (adr_i)
      ACOTB_OFS_A_IN1_P0:  begin hit_trim = 1'b1; hit_idx = 3'h0; end
      ACOTB_OFS_A_IN2_P0:  begin hit_trim = 1'b1; hit_idx = 3'h1; end
      ACOTB_OFS_A_IN1_P90: begin hit_trim = 1'b1; hit_idx = 3'h2; end
      ACOTB_OFS_A_IN2_P90: begin hit_trim = 1'b1; hit_idx = 3'h3; end
      ACOTB_OFS_B_IN1_P0:  begin hit_trim = 1'b1; hit_idx = 3'h4; end
      ACOTB_OFS_B_IN2_P0:  begin hit_trim = 1'b1; hit_idx = 3'h5; end
      default:             begin hit_trim = 1'b0; hit_idx = 3'h0; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  // priority: fuse copy first, then a taken software write on top of it
  // rdata only loads on a taken read, so dat_o holds between accesses
  always_comb begin
    next_ctrl      = ctrl;
    next_fuse_pend = fuse_pend;
    next_ack       = req;
    next_rdata     = rdata;
    for (int i = 0; i < ACOTB_NREG; i++) begin
      next_trim[i] = trim[i];
    end
    // fuse copy: first load after reset or any later reload request
    if (fuse_pend || fuse_load_i) begin
      for (int i = 0; i < ACOTB_NREG; i++) begin
        next_trim[i] = fuse_data_i[i*ACOTB_TRIM_W +: ACOTB_TRIM_W];
      end
      next_fuse_pend = 1'b0;
    end
    if (req && we_i) begin
      // software writes win over the fuse copy in the same cycle
      if (hit_trim) begin
        // all 16 bits are kept, reserved bits included
        if (wr_lo) next_trim[hit_idx][7:0]  = dat_i[7:0];
        if (wr_hi) next_trim[hit_idx][15:8] = dat_i[15:8];
      end else if (adr_i == ACOTB_OFS_CTRL && wr_lo) begin
        next_ctrl = dat_i[3:0];
      end
    end else if (req) begin
      // reads: trim and control data beyond 16 bits reads as zero
      if (hit_trim) begin
        next_rdata = {16'h0000, trim[hit_idx]};
      end else if (adr_i == ACOTB_OFS_CTRL) begin
        next_rdata = {28'h0000000, ctrl};
      end else if (adr_i == ACOTB_OFS_STAT) begin
        next_rdata = {3'h0, trim_b.valid, trim_b.offset,
                      3'h0, trim_a.valid, trim_a.offset};
      end else begin
        next_rdata = ACOTB_UNMAPPED_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset selection per core
  acotb_cond_type cond_a;   // core a operating condition
  acotb_cond_type cond_b;   // core b operating condition
  logic           fg_en;    // foreground calibration enabled

  assign fg_en      = ctrl[ACOTB_CTRL_FG_EN];
  assign cond_a.in2 = ctrl[ACOTB_CTRL_A_IN2];
  assign cond_a.p90 = ctrl[ACOTB_CTRL_A_P90];
  assign cond_b.in2 = ctrl[ACOTB_CTRL_B_IN2];
  // core b has no 90-degree register here, so it runs on phase 0 only
  assign cond_b.p90 = 1'b0;

  // outputs are registered, so a bus write reaches the cores one cycle later
  // trade-off: one cycle of lag buys offsets that never glitch at the cores
  always_comb begin
    // without calibration no register drives either core
    next_trim_a = '0;
    next_trim_b = '0;
    if (fg_en) begin
      next_trim_a.valid = 1'b1;
      next_trim_b.valid = 1'b1;
      unique case ({cond_a.p90, cond_a.in2})
        2'b00: next_trim_a.offset = trim[0][ACOTB_OFFSET_MSB:0];
        2'b01: next_trim_a.offset = trim[1][ACOTB_OFFSET_MSB:0];
        2'b10: next_trim_a.offset = trim[2][ACOTB_OFFSET_MSB:0];
        2'b11: next_trim_a.offset = trim[3][ACOTB_OFFSET_MSB:0];
      endcase
      if (cond_b.in2) begin
        next_trim_b.offset = trim[5][ACOTB_OFFSET_MSB:0];
      end else begin
        next_trim_b.offset = trim[4][ACOTB_OFFSET_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // one process only registers the next values; nothing is decided here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // calibration starts off, so no core sees a word before the fuse copy
      ctrl      <= ACOTB_CTRL_RESET;
      fuse_pend <= 1'b1;
      ack       <= 1'b0;
      rdata     <= ACOTB_RDATA_RESET;
      trim_a    <= '0;
      trim_b    <= '0;
      // trim contents are cleared until the fuse copy lands
      for (int i = 0; i < ACOTB_NREG; i++) begin
        trim[i] <= ACOTB_TRIM_RESET;
      end
    end else begin
      ctrl      <= next_ctrl;
      fuse_pend <= next_fuse_pend;
      ack       <= next_ack;
      rdata     <= next_rdata;
      trim_a    <= next_trim_a;
      trim_b    <= next_trim_b;
      for (int i = 0; i < ACOTB_NREG; i++) begin
        trim[i] <= next_trim[i];
      end
    end
  end

  // every output comes straight from a flip-flop
  assign ack_o         = ack;
  assign dat_o         = rdata;
  assign core_a_trim_o = trim_a;
  assign core_b_trim_o = trim_b;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // every check runs on the bus clock and sleeps while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a full-width trim write taken this cycle, not overlapped by a reload
  sequence s_trim_write(logic [11:0] ofs);
    req && we_i && adr_i == ofs && sel_i[1:0] == 2'b11 && !fuse_load_i;
  endsequence

  // selection: each core follows exactly one trim word
  a_a_p0_select: assert property (
    fg_en && !cond_a.p90 && !cond_a.in2 |=> core_a_trim_o.offset == $past(trim[0][11:0]))
    else $error("core a in1 phase0 offset wrong");
  a_a_in2_select: assert property (
    fg_en && !cond_a.p90 && cond_a.in2 |=> core_a_trim_o.offset == $past(trim[1][11:0]))
    else $error("core a in2 phase0 offset wrong");
  a_a_p90_select: assert property (
    fg_en && cond_a.p90 && !cond_a.in2 |=> core_a_trim_o.offset == $past(trim[2][11:0]))
    else $error("core a in1 phase90 offset wrong");
  a_a_in2_p90: assert property (
    fg_en && cond_a.p90 && cond_a.in2 |=> core_a_trim_o.offset == $past(trim[3][11:0]))
    else $error("core a in2 phase90 offset wrong");
  a_b_in1_select: assert property (
    fg_en && !cond_b.in2 |=> core_b_trim_o.offset == $past(trim[4][11:0]))
    else $error("core b in1 offset wrong");
  a_b_in2_select: assert property (
    fg_en && cond_b.in2 |=> core_b_trim_o.offset == $past(trim[5][11:0]))
    else $error("core b in2 offset wrong");
  a_full_width_write: assert property (
    s_trim_write(ACOTB_OFS_A_IN1_P0) |=> trim[0] == $past(dat_i[15:0]) ##1 ack_o == 1'b0)
    else $error("trim write not stored in full");
  a_fuse_copy: assert property (
    fuse_load_i && !(req && we_i) |=> trim[5] == $past(fuse_data_i[95:80]))
    else $error("fuse default not loaded");
  a_cal_off_idle: assert property (
    !fg_en |=> !core_a_trim_o.valid && !core_b_trim_o.valid && core_a_trim_o.offset == 12'h000)
    else $error("offset applied without calibration");

  // a bus read of the given address taken this cycle
  sequence s_bus_read(logic [11:0] ofs);
    req && !we_i && adr_i == ofs;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one answer per taken request, one cycle later
  a_ack_after_req: assert property (
    req |=> ack_o)
    else $error("bus request not answered");
  // a strobe still held after the answer must not be taken twice
  a_ack_single_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  // no strobe, no answer
  a_no_ack_idle: assert property (
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("acknowledge without request");

  ////////////////////////////////////////////////////////////////////////////
  // read data: trim words, control, status and unmapped places
  a_trim_read_data: assert property (
    s_bus_read(ACOTB_OFS_B_IN1_P0) |=> ack_o && dat_o == {16'h0000, $past(trim[4])})
    else $error("trim read returned wrong data");
  a_ctrl_read_data: assert property (
    s_bus_read(ACOTB_OFS_CTRL) |=> dat_o == {28'h0000000, $past(ctrl)})
    else $error("control read returned wrong data");
  // status shows what the cores were given at the taking edge
  a_stat_read_data: assert property (
    s_bus_read(ACOTB_OFS_STAT)
      |=> dat_o[12:0] == $past(core_a_trim_o) && dat_o[28:16] == $past(core_b_trim_o))
    else $error("status read returned wrong data");
  // unmapped places read as zero, so software sees no stale word
  a_unmapped_zero: assert property (
    req && !we_i && !hit_trim && adr_i != ACOTB_OFS_CTRL && adr_i != ACOTB_OFS_STAT
      |=> dat_o == ACOTB_UNMAPPED_DATA)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // writes: reserved bits are stored, disabled byte lanes are left alone
  a_reserved_kept: assert property (
    s_trim_write(ACOTB_OFS_B_IN2_P0) |=> trim[5][15:12] == $past(dat_i[15:12]))
    else $error("reserved trim bits not stored");
  // the copy owed after reset would fill the idle lane, so it is left out
  a_low_lane_only: assert property (
    req && we_i && adr_i == ACOTB_OFS_A_IN2_P0 && sel_i[1:0] == 2'b01 && !fuse_load_i && !fuse_pend
      |=> trim[1][15:8] == $past(trim[1][15:8]) && trim[1][7:0] == $past(dat_i[7:0]))
    else $error("byte lane write spilled");

  ////////////////////////////////////////////////////////////////////////////
  // fuse defaults: copied once after reset, later only on request
  a_fuse_after_reset: assert property (
    fuse_pend && !(req && we_i) |=> trim[0] == $past(fuse_data_i[15:0]) && !fuse_pend)
    else $error("fuse default missing after reset");
  // with no copy and no access a trim word must not drift
  a_trim_holds: assert property (
    !fuse_pend && !fuse_load_i && !req |=> trim[2] == $past(trim[2]))
    else $error("trim word changed on its own");

  ////////////////////////////////////////////////////////////////////////////
  // calibration state gates both cores together
  a_cal_on_valid: assert property (
    fg_en |=> core_a_trim_o.valid && core_b_trim_o.valid)
    else $error("calibration on but offset not applied");
  a_b_cal_off: assert property (
    !fg_en |=> core_b_trim_o.offset == 12'h000)
    else $error("core b offset applied without calibration");

endmodule : acotb_bank
`default_nettype wire

// >>> hdl/acotb_pkg.sv
// package: register map, field layout and carrier types for the offset trim bank
`default_nettype none
package acotb_pkg;

  // register byte offsets (wishbone byte addresses carry these directly)
  localparam logic [11:0] ACOTB_OFS_A_IN1_P0  = 12'h344;
  localparam logic [11:0] ACOTB_OFS_A_IN2_P0  = 12'h346;
  localparam logic [11:0] ACOTB_OFS_A_IN1_P90 = 12'h348;
  localparam logic [11:0] ACOTB_OFS_A_IN2_P90 = 12'h34a;
  localparam logic [11:0] ACOTB_OFS_B_IN1_P0  = 12'h34c;
  localparam logic [11:0] ACOTB_OFS_B_IN2_P0  = 12'h34e;
  // control register of our own: fg calibration enable, input and phase selects
  localparam logic [11:0] ACOTB_OFS_CTRL      = 12'h380;
  // status register of our own: selected offsets of both cores
  localparam logic [11:0] ACOTB_OFS_STAT      = 12'h384;

  // number of trim registers
  localparam int ACOTB_NREG = 6;

  // field layout of a trim register
  localparam int ACOTB_TRIM_W   = 16;
  localparam int ACOTB_OFFSET_W = 12;
  localparam int ACOTB_OFFSET_MSB = 11;
  localparam int ACOTB_RSVD_LSB   = 12;

  // control field positions
  localparam int ACOTB_CTRL_FG_EN  = 0;
  localparam int ACOTB_CTRL_A_IN2  = 1;
  localparam int ACOTB_CTRL_A_P90  = 2;
  localparam int ACOTB_CTRL_B_IN2  = 3;
  localparam logic [3:0] ACOTB_CTRL_RESET = 4'h0;

  // value driven onto the bus for an unmapped read
  localparam logic [31:0] ACOTB_UNMAPPED_DATA = 32'h0000_0000;

  // values held during reset: trims are cleared until the fuse copy lands
  localparam logic [15:0] ACOTB_TRIM_RESET  = 16'h0000;
  localparam logic [31:0] ACOTB_RDATA_RESET = 32'h0000_0000;

  // per-core applied offset
  typedef struct packed {
    logic                      valid;
    logic [ACOTB_OFFSET_W-1:0] offset;
  } acotb_trim_type;

  // operating condition of one core
  typedef struct packed {
    logic in2;
    logic p90;
  } acotb_cond_type;

endpackage : acotb_pkg
`default_nettype wire

// >>> test/adc_core_offset_trim_bank_test.sv
// self-checking bench for the offset trim bank: bus access, fuse defaults, core selection
`timescale 1ns/1ps
`default_nettype none
module adc_core_offset_trim_bank_test;
  import acotb_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic           clk;        // 100 mhz clock
  logic           rst;        // synchronous reset
  logic           cyc;        // bus cycle
  logic           stb;        // bus strobe
  logic           we;         // write when high
  logic [11:0]    adr;        // byte address
  logic [3:0]     sel;        // byte lanes
  logic [3:0]     lanes;      // byte lanes for the next access
  logic [31:0]    wdat;       // write data
  logic [31:0]    rdat;       // read data
  logic           ack;        // bus answer
  logic [95:0]    fuse;       // factory defaults
  logic           fuse_ld;    // fuse copy request
  acotb_trim_type core_a;     // offset applied to core a
  acotb_trim_type core_b;     // offset applied to core b
  logic [15:0]    shadow [6]; // expected register contents
  logic [31:0]    q;          // last read data
  integer         seed;       // fixed seed keeps runs repeatable
  int             fails;      // mismatch count
  int             tests_run;  // comparison count
  // trim addresses in fuse word order
  logic [11:0]    addr_tab [6] = '{ACOTB_OFS_A_IN1_P0, ACOTB_OFS_A_IN2_P0, ACOTB_OFS_A_IN1_P90,
                                   ACOTB_OFS_A_IN2_P90, ACOTB_OFS_B_IN1_P0, ACOTB_OFS_B_IN2_P0};

  always #5 clk = ~clk;

  acotb_bank dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .fuse_data_i(fuse), .fuse_load_i(fuse_ld),
    .core_a_trim_o(core_a), .core_b_trim_o(core_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // one classic wishbone access; the wait is bounded so a silent slave cannot hang us
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= lanes;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
  endtask : wb

  // read every trim word back against the shadow copy
  task automatic read_all;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, addr_tab[i], 32'h0, r);
      check("trim word", r, {16'h0, shadow[i]});
    end
  endtask : read_all

  // expected core output: only one register per core, nothing with calibration off
  function automatic logic [12:0] expect_trim(input logic [3:0] c, input logic b);
    logic [2:0] idx;
    idx = b ? {2'b10, c[3]} : {1'b0, c[2], c[1]};
    if (!c[0]) return 13'h0;
    return {1'b1, shadow[idx][11:0]};
  endfunction : expect_trim

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h8347;
    clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0; sel = 4'h0; wdat = 32'h0;
    fails = 0; tests_run = 0; fuse_ld = 1'b0;
    lanes = 4'hf;
    fuse = {$random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < 6; i++) shadow[i] = fuse[16*i +: 16];
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // defaults come from the fuse words after reset
    read_all();
    // overwrite with random words, all-ones and zero among them
    for (int i = 0; i < 6; i++) begin
      q = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      shadow[i] = q[15:0];
      wb(1'b1, addr_tab[i], q, q);
    end
    // low byte lane only: the high byte and reserved bits must stay
    lanes = 4'h1;
    wb(1'b1, ACOTB_OFS_A_IN2_P0, 32'hffff_a5c3, q);
    lanes = 4'hf;
    shadow[1][7:0] = 8'hc3;
    read_all();
    // an unmapped place reads zero
    wb(1'b0, 12'h300, 32'h0, q);
    check("unmapped", q, 32'h0);
    // every control combination, calibration off and on
    for (int c = 0; c < 16; c++) begin
      wb(1'b1, ACOTB_OFS_CTRL, {28'h0, c[3:0]}, q);
      check("core a", {19'h0, core_a}, {19'h0, expect_trim(c[3:0], 1'b0)});
      check("core b", {19'h0, core_b}, {19'h0, expect_trim(c[3:0], 1'b1)});
      wb(1'b0, ACOTB_OFS_CTRL, 32'h0, q);
      check("control", q, {28'h0, c[3:0]});
      wb(1'b0, ACOTB_OFS_STAT, 32'h0, q);
      check("status", q, {3'h0, expect_trim(c[3:0], 1'b1), 3'h0, expect_trim(c[3:0], 1'b0)});
    end
    // fuse reload later in the run replaces software values
    q = $random(seed);
    fuse    <= {q, q ^ 32'h5a5a_a5a5, ~q};
    fuse_ld <= 1'b1;
    @(posedge clk);
    fuse_ld <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    for (int i = 0; i < 6; i++) shadow[i] = fuse[16*i +: 16];
    check("core a reload", {19'h0, core_a}, {19'h0, expect_trim(4'hf, 1'b0)});
    check("core b reload", {19'h0, core_b}, {19'h0, expect_trim(4'hf, 1'b1)});
    read_all();
    // reset in mid-run: control clears, fresh fuse words are copied once
    q = $random(seed);
    fuse <= {~q, q, q ^ 32'h0f0f_f0f0};
    rst  <= 1'b1;
    repeat (16) @(posedge clk);
    rst  <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) shadow[i] = fuse[16*i +: 16];
    check("core a after reset", {19'h0, core_a}, 32'h0);
    check("core b after reset", {19'h0, core_b}, 32'h0);
    read_all();
    wb(1'b0, ACOTB_OFS_CTRL, 32'h0, q);
    check("control after reset", q, 32'h0);
    print_verdict();
  end
endmodule : adc_core_offset_trim_bank_test
`default_nettype wire
